// [pkg/tx_tune_pkg.sv]
// Constants and types shared by the transmit tuning block
package tx_tune_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses
   localparam int          ADDR_W          = 12;
   localparam logic [11:0] RETRY_ADDR      = 12'h008;
   localparam logic [11:0] STATUS_ADDR     = 12'ha80;
   localparam logic [11:0] CTRL_SET_ADDR   = 12'ha88;
   localparam logic [11:0] CTRL_CLR_ADDR   = 12'ha8c;

   ////////////////////////////////////////////////////////////////////////////
   // Control word layout
   localparam logic [31:0] CTRL_RESET      = 32'h0000_1000;
   localparam logic [31:0] CTRL_WMASK      = 32'h0000_3582;
   localparam int          THR_LSB         = 12;
   localparam int          MPEG_BIT        = 10;
   localparam int          DV_BIT          = 8;
   localparam int          PRIO_BIT        = 7;
   localparam int          ACCEL_BIT       = 1;
   localparam logic [3:0]  RETRY_RESET     = 4'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Status word layout
   localparam int          ST_SEND_BIT     = 0;
   localparam int          ST_DROP_BIT     = 1;
   localparam int          ST_RETRY_BIT    = 2;
   localparam int          ST_SFWD_BIT     = 3;
   localparam int          ST_LOADED_LSB   = 16;

   ////////////////////////////////////////////////////////////////////////////
   // Threshold codes and byte counts
   localparam logic [1:0]  THR_STORE_FWD   = 2'h0;
   localparam logic [1:0]  THR_1K7         = 2'h1;
   localparam logic [1:0]  THR_1K          = 2'h2;
   localparam logic [1:0]  THR_512         = 2'h3;
   localparam logic [12:0] THR_2K_BYTES    = 13'h0800;
   localparam logic [12:0] THR_1K7_BYTES   = 13'h06cc;
   localparam logic [12:0] THR_1K_BYTES    = 13'h0400;
   localparam logic [12:0] THR_512_BYTES   = 13'h0200;
   localparam logic [12:0] BYTES_PER_WORD  = 13'h0004;
   localparam logic [12:0] LOADED_MAX      = 13'h1fff;

   ////////////////////////////////////////////////////////////////////////////
   // Stream format codes
   localparam logic [5:0]  FORMAT_MPEG     = 6'h20;
   localparam logic [5:0]  FORMAT_DV       = 6'h00;

   typedef enum {GATE_IDLE, GATE_SEND, GATE_DROP} gate_e;

endpackage

// [core/tx_fifo.sv]
// Word FIFO between host fill side and transmit drain side
`timescale 1ns/1ps
`default_nettype none

module tx_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 4
) (
   input  wire logic             mclk_in,
   input  wire logic             resetn_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   output logic [WIDTH-1:0]      out_data_out,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic                  full_out
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wptr;
      logic [AW-1:0]               rptr;
      logic [AW:0]                 count;
      logic                        ready;
      logic                        valid;
   } fifo_s;

   fifo_s r_reg;
   fifo_s r_next;
   logic  push;
   logic  pop;

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      r_next = r_reg;
      push   = in_valid_in && r_reg.ready;
      pop    = out_ready_in && r_reg.valid;
      if (push) begin
         r_next.mem[r_reg.wptr] = in_data_in;
         r_next.wptr = (r_reg.wptr == AW'(DEPTH - 1)) ? '0 : r_reg.wptr + 1'b1;
      end
      if (pop) begin
         r_next.rptr = (r_reg.rptr == AW'(DEPTH - 1)) ? '0 : r_reg.rptr + 1'b1;
      end
      if (push && !pop) begin
         r_next.count = r_reg.count + 1'b1;
      end else if (pop && !push) begin
         r_next.count = r_reg.count - 1'b1;
      end
      r_next.ready = (r_next.count != (AW+1)'(DEPTH));
      r_next.valid = (r_next.count != '0);
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign in_ready_out  = r_reg.ready;
   assign out_valid_out = r_reg.valid;
   assign out_data_out  = r_reg.mem[r_reg.rptr];
   assign full_out      = !r_reg.ready;

endmodule

`default_nettype wire

// [core/tx_start_gate.sv]
// Start decision for one packet from threshold and fill state
`timescale 1ns/1ps
`default_nettype none

module tx_start_gate (
   input  wire logic [1:0]  thr_sel_in,
   input  wire logic        retry_mode_in,
   input  wire logic        retries_zero_in,
   input  wire logic [12:0] loaded_bytes_in,
   input  wire logic        eop_pending_in,
   input  wire logic        fifo_valid_in,
   input  wire logic        fifo_full_in,
   output logic             store_fwd_out,
   output logic             start_out
);
   // Threshold code to byte count
   function automatic logic [12:0] thr_bytes(input logic [1:0] sel);
      logic [12:0] b;
      b = tx_tune_pkg::THR_2K_BYTES;
      case (sel)
         tx_tune_pkg::THR_1K7: b = tx_tune_pkg::THR_1K7_BYTES;
         tx_tune_pkg::THR_1K:  b = tx_tune_pkg::THR_1K_BYTES;
         tx_tune_pkg::THR_512: b = tx_tune_pkg::THR_512_BYTES;
         default:              b = tx_tune_pkg::THR_2K_BYTES;
      endcase
      return b;
   endfunction

   always_comb begin
      store_fwd_out = (thr_sel_in == tx_tune_pkg::THR_STORE_FWD)
                      || retry_mode_in
                      || retries_zero_in;
      start_out = fifo_valid_in
                  && (eop_pending_in
                      || (!store_fwd_out
                          && ((loaded_bytes_in >= thr_bytes(thr_sel_in))
                              || fifo_full_in)));
   end

endmodule

`default_nettype wire

// [core/tx_tuning.sv]
// Async transmit threshold gate with enhancement control word
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module tx_tuning #(
   parameter int RETRY_W    = 4,
   parameter int FIFO_DEPTH = 4
) (
   input  wire logic                           mclk_in,
   input  wire logic                           resetn_in,
   input  wire logic [tx_tune_pkg::ADDR_W-1:0] reg_addr_in,
   input  wire logic [31:0]                    reg_wdata_in,
   input  wire logic                           reg_wr_in,
   input  wire logic                           reg_rd_in,
   output logic      [31:0]                    reg_rdata_out,
   input  wire logic [31:0]                    host_data_in,
   input  wire logic                           host_valid_in,
   input  wire logic                           host_last_in,
   output logic                                host_ready_out,
   output logic      [31:0]                    tx_data_out,
   output logic                                tx_valid_out,
   output logic                                tx_last_out,
   input  wire logic                           tx_ready_in,
   output logic                                tx_underrun_out,
   input  wire logic [5:0]                     stream_format_code_in,
   output logic                                mpeg_stamp_apply_out,
   output logic                                dv_stamp_apply_out,
   output logic                                priority_arb_out,
   output logic                                accel_notice_out
);
   localparam int EW = $clog2(FIFO_DEPTH + 1);

   typedef struct packed {
      logic [31:0]         ctrl;
      logic [RETRY_W-1:0]  retries;
      logic [31:0]         rdata;
      tx_tune_pkg::gate_e  gate;
      logic                retry_mode;
      logic [12:0]         loaded;
      logic [EW-1:0]       eop_cnt;
      logic [31:0]         tx_data;
      logic                tx_valid;
      logic                tx_last;
      logic                tx_err;
      logic                mpeg_apply;
      logic                dv_apply;
      logic                prio;
      logic                accel;
   } state_s;

   state_s      r_reg;
   state_s      r_next;
   logic [32:0] fifo_out;
   logic        fifo_valid;
   logic        fifo_ready;
   logic        fifo_full;
   logic        fifo_pop;
   logic        push;
   logic        pop_fire;
   logic        store_fwd;
   logic        start;

   // Status word from current gate state
   function automatic logic [31:0] status_word(input state_s s, input logic sf);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[tx_tune_pkg::ST_SEND_BIT]  = (s.gate == tx_tune_pkg::GATE_SEND);
      w[tx_tune_pkg::ST_DROP_BIT]  = (s.gate == tx_tune_pkg::GATE_DROP);
      w[tx_tune_pkg::ST_RETRY_BIT] = s.retry_mode;
      w[tx_tune_pkg::ST_SFWD_BIT]  = sf;
      w[tx_tune_pkg::ST_LOADED_LSB +: 13] = s.loaded;
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Data buffer and start decision
   tx_fifo #(
      .WIDTH (33),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .mclk_in       (mclk_in),
      .resetn_in     (resetn_in),
      .in_data_in    ({host_last_in, host_data_in}),
      .in_valid_in   (host_valid_in),
      .in_ready_out  (fifo_ready),
      .out_data_out  (fifo_out),
      .out_valid_out (fifo_valid),
      .out_ready_in  (fifo_pop),
      .full_out      (fifo_full)
   );

   tx_start_gate u_gate (
      .thr_sel_in      (r_reg.ctrl[tx_tune_pkg::THR_LSB +: 2]),
      .retry_mode_in   (r_reg.retry_mode),
      .retries_zero_in (r_reg.retries == '0),
      .loaded_bytes_in (r_reg.loaded),
      .eop_pending_in  (r_reg.eop_cnt != '0),
      .fifo_valid_in   (fifo_valid),
      .fifo_full_in    (fifo_full),
      .store_fwd_out   (store_fwd),
      .start_out       (start)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      r_next   = r_reg;
      push     = host_valid_in && fifo_ready;
      fifo_pop = ((r_reg.gate == tx_tune_pkg::GATE_SEND)
                  && (!r_reg.tx_valid || tx_ready_in))
                 || (r_reg.gate == tx_tune_pkg::GATE_DROP);
      pop_fire = fifo_pop && fifo_valid;

      // Register writes
      if (reg_wr_in) begin
         if (reg_addr_in == tx_tune_pkg::CTRL_SET_ADDR) begin
            r_next.ctrl = r_reg.ctrl | (reg_wdata_in & tx_tune_pkg::CTRL_WMASK);
         end else if (reg_addr_in == tx_tune_pkg::CTRL_CLR_ADDR) begin
            r_next.ctrl = r_reg.ctrl & ~(reg_wdata_in & tx_tune_pkg::CTRL_WMASK);
         end else if (reg_addr_in == tx_tune_pkg::RETRY_ADDR) begin
            r_next.retries = reg_wdata_in[RETRY_W-1:0];
         end
      end

      // Register reads, data in the following cycle
      r_next.rdata = 32'h0000_0000;
      if (reg_rd_in) begin
         if (reg_addr_in == tx_tune_pkg::CTRL_SET_ADDR) begin
            r_next.rdata = r_reg.ctrl;
         end else if (reg_addr_in == tx_tune_pkg::CTRL_CLR_ADDR) begin
            r_next.rdata = r_reg.ctrl;
         end else if (reg_addr_in == tx_tune_pkg::RETRY_ADDR) begin
            r_next.rdata = 32'(r_reg.retries);
         end else if (reg_addr_in == tx_tune_pkg::STATUS_ADDR) begin
            r_next.rdata = status_word(r_reg, store_fwd);
         end
      end

      // Per-packet loaded byte count
      if (push) begin
         if (host_last_in) begin
            r_next.loaded = 13'h0000;
         end else if (r_reg.loaded > tx_tune_pkg::LOADED_MAX - tx_tune_pkg::BYTES_PER_WORD) begin
            r_next.loaded = tx_tune_pkg::LOADED_MAX;
         end else begin
            r_next.loaded = r_reg.loaded + tx_tune_pkg::BYTES_PER_WORD;
         end
      end

      // End tokens held in the buffer
      if ((push && host_last_in) && !(pop_fire && fifo_out[32])) begin
         r_next.eop_cnt = r_reg.eop_cnt + 1'b1;
      end else if (!(push && host_last_in) && (pop_fire && fifo_out[32])) begin
         r_next.eop_cnt = r_reg.eop_cnt - 1'b1;
      end

      // Transmit stage and gate
      r_next.tx_err = 1'b0;
      if (tx_ready_in) begin
         r_next.tx_valid = 1'b0;
      end
      case (r_reg.gate)
         tx_tune_pkg::GATE_IDLE: begin
            if (start) begin
               r_next.gate = tx_tune_pkg::GATE_SEND;
            end
         end
         tx_tune_pkg::GATE_SEND: begin
            if (pop_fire) begin
               r_next.tx_data  = fifo_out[31:0];
               r_next.tx_last  = fifo_out[32];
               r_next.tx_valid = 1'b1;
               if (fifo_out[32]) begin
                  r_next.gate       = tx_tune_pkg::GATE_IDLE;
                  r_next.retry_mode = 1'b0;
               end
            end else if (tx_ready_in) begin
               r_next.tx_err     = 1'b1;
               r_next.retry_mode = 1'b1;
               r_next.gate       = tx_tune_pkg::GATE_DROP;
            end
         end
         tx_tune_pkg::GATE_DROP: begin
            if (pop_fire && fifo_out[32]) begin
               r_next.gate = tx_tune_pkg::GATE_IDLE;
            end
         end
         default: begin
            r_next.gate = tx_tune_pkg::GATE_IDLE;
         end
      endcase

      // Enhancement enables
      r_next.mpeg_apply = r_reg.ctrl[tx_tune_pkg::MPEG_BIT]
                          && (stream_format_code_in == tx_tune_pkg::FORMAT_MPEG);
      r_next.dv_apply   = r_reg.ctrl[tx_tune_pkg::DV_BIT]
                          && (stream_format_code_in == tx_tune_pkg::FORMAT_DV);
      r_next.prio       = r_reg.ctrl[tx_tune_pkg::PRIO_BIT];
      r_next.accel      = r_reg.ctrl[tx_tune_pkg::ACCEL_BIT];
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         r_reg         <= '0;
         r_reg.ctrl    <= tx_tune_pkg::CTRL_RESET;
         r_reg.retries <= RETRY_W'(tx_tune_pkg::RETRY_RESET);
         r_reg.gate    <= tx_tune_pkg::GATE_IDLE;
      end else begin
         r_reg <= r_next;
      end
   end

   assign reg_rdata_out        = r_reg.rdata;
   assign host_ready_out       = fifo_ready;
   assign tx_data_out          = r_reg.tx_data;
   assign tx_valid_out         = r_reg.tx_valid;
   assign tx_last_out          = r_reg.tx_last;
   assign tx_underrun_out      = r_reg.tx_err;
   assign mpeg_stamp_apply_out = r_reg.mpeg_apply;
   assign dv_stamp_apply_out   = r_reg.dv_apply;
   assign priority_arb_out     = r_reg.prio;
   assign accel_notice_out     = r_reg.accel;

endmodule

`default_nettype wire

// [sim/tx_tuning_checker.sv]
// Port assertions for the transmit tuning block
`timescale 1ns/1ps
`default_nettype none
module tx_tuning_checker #(
   parameter int RETRY_W    = 4,
   parameter int FIFO_DEPTH = 4
) (
   input wire logic        mclk_in,
   input wire logic        resetn_in,
   input wire logic [11:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic [31:0] host_data_in,
   input wire logic        host_valid_in,
   input wire logic        host_last_in,
   input wire logic        host_ready_out,
   input wire logic [31:0] tx_data_out,
   input wire logic        tx_valid_out,
   input wire logic        tx_last_out,
   input wire logic        tx_ready_in,
   input wire logic        tx_underrun_out,
   input wire logic [5:0]  stream_format_code_in,
   input wire logic        mpeg_stamp_apply_out,
   input wire logic        dv_stamp_apply_out,
   input wire logic        priority_arb_out,
   input wire logic        accel_notice_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   ////////////////////////////////////////////////////////////////////////////
   a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
      else $error("read data not zero outside read cycle");
   a_ctrl_reserved: assert property ($past(reg_rd_in) && ($past(reg_addr_in) ==
      tx_tune_pkg::CTRL_SET_ADDR || $past(reg_addr_in) == tx_tune_pkg::CTRL_CLR_ADDR)
      |-> (reg_rdata_out & ~tx_tune_pkg::CTRL_WMASK) == 32'h0)
      else $error("reserved control bit reads one");
   a_unmapped_zero: assert property (reg_rd_in && !(reg_addr_in inside {12'h008, 12'ha80,
      12'ha88, 12'ha8c}) |=> reg_rdata_out == 32'h0)
      else $error("unmapped read not zero");
   a_prio_set: assert property (reg_wr_in && reg_addr_in == tx_tune_pkg::CTRL_SET_ADDR
      && reg_wdata_in[7] |=> ##1 priority_arb_out)
      else $error("priority output did not rise");
   a_accel_clear: assert property (reg_wr_in && reg_addr_in == tx_tune_pkg::CTRL_CLR_ADDR
      && reg_wdata_in[1] |=> ##1 !accel_notice_out)
      else $error("acceleration output did not fall");
   a_mpeg_format: assert property (mpeg_stamp_apply_out |->
      $past(stream_format_code_in) == tx_tune_pkg::FORMAT_MPEG)
      else $error("mpeg stamp on wrong format");
   a_dv_format: assert property (dv_stamp_apply_out |->
      $past(stream_format_code_in) == tx_tune_pkg::FORMAT_DV)
      else $error("dv stamp on wrong format");
   a_tx_hold: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out &&
      $stable(tx_data_out) && $stable(tx_last_out))
      else $error("transmit word dropped while stalled");
   a_underrun_pulse: assert property (tx_underrun_out |=> !tx_underrun_out)
      else $error("underrun pulse too long");
   a_underrun_demand: assert property (tx_underrun_out |-> $past(tx_ready_in))
      else $error("underrun without demand");
   c_underrun: cover property (tx_underrun_out);
   c_last_sent: cover property (tx_valid_out && tx_ready_in && tx_last_out);
   c_stall: cover property (tx_valid_out && !tx_ready_in);
endmodule
bind tx_tuning tx_tuning_checker #(.RETRY_W(RETRY_W), .FIFO_DEPTH(FIFO_DEPTH)) i_chk (
   .mclk_in(mclk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .host_data_in(host_data_in), .host_valid_in(host_valid_in),
   .host_last_in(host_last_in), .host_ready_out(host_ready_out), .tx_data_out(tx_data_out),
   .tx_valid_out(tx_valid_out), .tx_last_out(tx_last_out), .tx_ready_in(tx_ready_in),
   .tx_underrun_out(tx_underrun_out), .stream_format_code_in(stream_format_code_in),
   .mpeg_stamp_apply_out(mpeg_stamp_apply_out), .dv_stamp_apply_out(dv_stamp_apply_out),
   .priority_arb_out(priority_arb_out), .accel_notice_out(accel_notice_out));
`default_nettype wire

// [sim/phy_sink.sv]
// Serial bus side model that takes transmit words
`timescale 1ns/1ps
`default_nettype none
module phy_sink (
   input  wire logic mclk_in,
   input  wire logic resetn_in,
   input  wire logic valid_in,
   input  wire logic last_in,
   input  wire logic stall_in,
   output logic      ready_out,
   output int        words_out,
   output int        pkts_out
);
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ready_out <= 1'b0;
         words_out <= 0;
         pkts_out  <= 0;
      end else begin
         ready_out <= !stall_in; // Demands data even when none is valid
         if (valid_in && ready_out) begin
            words_out <= words_out + 1;
            if (last_in) begin
               pkts_out <= pkts_out + 1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// [sim/tx_tuning_tb.sv]
// Self-checking testbench for the transmit tuning block
`timescale 1ns/1ps
`default_nettype none
module tx_tuning_tb;
   logic        mclk_in = 1'b0;
   logic        resetn_in = 1'b0;
   logic [11:0] reg_addr_in = 12'h0;
   logic [31:0] reg_wdata_in = 32'h0;
   logic        reg_wr_in = 1'b0;
   logic        reg_rd_in = 1'b0;
   logic [31:0] reg_rdata_out;
   logic [31:0] host_data_in = 32'h0;
   logic        host_valid_in = 1'b0;
   logic        host_last_in = 1'b0;
   logic        host_ready_out;
   logic [31:0] tx_data_out;
   logic        tx_valid_out;
   logic        tx_last_out;
   logic        tx_ready_in;
   logic        tx_underrun_out;
   logic [5:0]  stream_format_code_in = 6'h00;
   logic        mpeg_stamp_apply_out;
   logic        dv_stamp_apply_out;
   logic        priority_arb_out;
   logic        accel_notice_out;
   logic        stall = 1'b0;
   int          words;
   int          pkts;
   int          n_under = 0;
   int          n_mismatch = 0;
   int          tests_run = 0;
   logic [5:0]  fmts [3] = '{6'h20, 6'h00, 6'h15};
   always #4 mclk_in = ~mclk_in;
   tx_tuning #(.RETRY_W(4), .FIFO_DEPTH(4)) i_dut (
      .mclk_in(mclk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .host_data_in(host_data_in),
      .host_valid_in(host_valid_in), .host_last_in(host_last_in),
      .host_ready_out(host_ready_out), .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out),
      .tx_last_out(tx_last_out), .tx_ready_in(tx_ready_in), .tx_underrun_out(tx_underrun_out),
      .stream_format_code_in(stream_format_code_in), .mpeg_stamp_apply_out(mpeg_stamp_apply_out),
      .dv_stamp_apply_out(dv_stamp_apply_out), .priority_arb_out(priority_arb_out),
      .accel_notice_out(accel_notice_out));
   phy_sink i_sink (.mclk_in(mclk_in), .resetn_in(resetn_in), .valid_in(tx_valid_out),
      .last_in(tx_last_out), .stall_in(stall), .ready_out(tx_ready_in), .words_out(words),
      .pkts_out(pkts));
   always @(negedge mclk_in) begin
      if (resetn_in && tx_underrun_out === 1'b1) begin
         n_under++;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic timed_out;
      n_mismatch++;
      $display("[FAIL] %0t wait ran out", $time);
      complete_run();
   endtask
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge mclk_in);
      reg_wr_in    <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge mclk_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge mclk_in);
      reg_rd_in   <= 1'b0;
      #1;
      chk32(reg_rdata_out & m, e);
   endtask
   task automatic push(input logic lst);
      int i;
      @(posedge mclk_in);
      host_data_in  <= host_data_in + 32'h1;
      host_last_in  <= lst;
      host_valid_in <= 1'b1;
      @(negedge mclk_in);
      for (i = 0; i < 50 && host_ready_out !== 1'b1; i++) @(negedge mclk_in);
      if (i == 50) timed_out();
      @(posedge mclk_in);
      host_valid_in <= 1'b0;
   endtask
   task automatic wait_words(input int n);
      int i;
      for (i = 0; i < 100 && words != n; i++) @(negedge mclk_in);
      if (i == 100) timed_out();
      chk32(32'(words), 32'(n));
   endtask
   task automatic sf_packet(input int n);
      @(posedge mclk_in);
      stall <= 1'b1;
      repeat (3) push(1'b0);
      repeat (10) @(negedge mclk_in);
      chk1(tx_valid_out, 1'b0);
      push(1'b1);
      repeat (10) @(negedge mclk_in);
      chk1(tx_valid_out, 1'b1);
      @(posedge mclk_in);
      stall <= 1'b0;
      wait_words(n);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge mclk_in);
      resetn_in <= 1'b1;
      rd(tx_tune_pkg::CTRL_SET_ADDR, 32'hffff_ffff, tx_tune_pkg::CTRL_RESET);
      rd(tx_tune_pkg::RETRY_ADDR, 32'hffff_ffff, 32'h0);
      wr(tx_tune_pkg::CTRL_SET_ADDR, 32'hffff_ffff);
      rd(tx_tune_pkg::CTRL_CLR_ADDR, 32'hffff_ffff, 32'h0000_3582);
      wr(tx_tune_pkg::CTRL_CLR_ADDR, 32'h0000_3000);
      rd(tx_tune_pkg::CTRL_SET_ADDR, 32'hffff_ffff, 32'h0000_0582);
      chk1(priority_arb_out, 1'b1);
      chk1(accel_notice_out, 1'b1);
      wr(tx_tune_pkg::CTRL_CLR_ADDR, 32'h0000_0082);
      rd(12'h444, 32'hffff_ffff, 32'h0);
      chk1(priority_arb_out, 1'b0);
      chk1(accel_notice_out, 1'b0);
      for (int k = 0; k < 3; k++) begin
         @(posedge mclk_in);
         stream_format_code_in <= fmts[k];
         repeat (2) @(posedge mclk_in);
         #1;
         chk1(mpeg_stamp_apply_out, fmts[k] == tx_tune_pkg::FORMAT_MPEG);
         chk1(dv_stamp_apply_out, fmts[k] == tx_tune_pkg::FORMAT_DV);
      end
      wr(tx_tune_pkg::CTRL_SET_ADDR, 32'h0000_3000);
      sf_packet(4);
      chk32(tx_data_out, 32'h0000_0004);
      chk1(tx_last_out, 1'b1);
      rd(tx_tune_pkg::STATUS_ADDR, 32'h1fff_0000, 32'h0);
      wr(tx_tune_pkg::RETRY_ADDR, 32'h1);
      wr(tx_tune_pkg::CTRL_CLR_ADDR, 32'h0000_3000);
      sf_packet(8);
      wr(tx_tune_pkg::CTRL_SET_ADDR, 32'h0000_3000);
      push(1'b0);
      push(1'b0);
      rd(tx_tune_pkg::STATUS_ADDR, 32'h1fff_0000, 32'h0008_0000);
      push(1'b1);
      wait_words(11);
      repeat (4) push(1'b0);
      wait_words(15);
      chk32(tx_data_out, 32'h0000_000f);
      chk1(tx_last_out, 1'b0);
      repeat (10) @(negedge mclk_in);
      chk32(32'(n_under), 32'h1);
      rd(tx_tune_pkg::STATUS_ADDR, 32'h0000_000c, 32'h0000_000c);
      push(1'b1);
      repeat (10) @(negedge mclk_in);
      chk32(32'(words), 32'd15);
      push(1'b0);
      push(1'b0);
      push(1'b1);
      wait_words(18);
      chk32(tx_data_out, 32'h0000_0013);
      chk32(32'(pkts), 32'd4);
      rd(tx_tune_pkg::STATUS_ADDR, 32'h0000_0004, 32'h0);
      complete_run();
   end
endmodule
`default_nettype wire
